// ==== common/eedms_arr_if.sv ====
// Access port between the sequencer and the EEPROM array
`timescale 1ns/1ns
`default_nettype none
interface eedms_arr_if #(parameter int AW = 9, parameter int DW = 8);
    logic we;
    logic re;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;
    modport ctrl (output we, re, addr, wdata, input rdata);
    modport array (input we, re, addr, wdata, output rdata);
endinterface : eedms_arr_if
`default_nettype wire

// ==== common/eedms_pkg.sv ====
// Shared constants and types of the data EEPROM sequencer
package eedms_pkg;
    // Register byte addresses on the AXI4-Lite port
    localparam int AXI_AW = 5;
    localparam logic [4:0] REG_ADDR_LOW = 5'h00;
    localparam logic [4:0] REG_ADDR_HIGH = 5'h04;
    localparam logic [4:0] REG_DATA = 5'h08;
    localparam logic [4:0] REG_CONTROL = 5'h0c;
    localparam logic [4:0] REG_STATUS = 5'h10;
    // Control and status register fields
    localparam int CTL_TIME_SEL = 7;
    localparam int CTL_ERASE_EN = 6;
    localparam int CTL_ERASE_GO = 5;
    localparam int CTL_MODE = 4;
    localparam int CTL_WRITE_EN = 3;
    localparam int CTL_WRITE_GO = 2;
    localparam int CTL_READ_EN = 1;
    localparam int CTL_READ_GO = 0;
    localparam int STS_IRQ = 0;
    // Reset values
    localparam logic [7:0] ADDR_LOW_RST = 8'h00;
    localparam logic ADDR_HIGH_RST = 1'b0;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [7:0] CONTROL_RST = 8'h00;
    // Array geometry
    localparam int ARR_AW = 9;
    localparam int ARR_DW = 8;
    localparam int PAGE_BYTES = 16;
    localparam int OFS_W = 4;
    localparam logic [3:0] OFS_LAST = 4'hf;
    // Cycle timing and bus response codes
    localparam int CLK_PERIOD_NS = 10;
    localparam int ERASE_T0_NS = 3200000;
    localparam int WRITE_T0_NS = 2200000;
    localparam int ERASE_T1_NS = 3700000;
    localparam int WRITE_T1_NS = 3000000;
    localparam int ERASE_T0_CYC = (ERASE_T0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_T0_CYC = (WRITE_T0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ERASE_T1_CYC = (ERASE_T1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_T1_CYC = (WRITE_T1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TMR_W = 20;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [2:0] {ST_IDLE, ST_READ, ST_ERASE, ST_PROG, ST_COMMIT} eedms_state_t;
endpackage : eedms_pkg

// ==== design/eedms_array.sv ====
// Nonvolatile byte array with registered read data
`timescale 1ns/1ns
`default_nettype none
module eedms_array #(
    parameter int DEPTH = 512
) (
    input wire logic clk,  // System clock
    input wire logic ce,  // Clock enable
    eedms_arr_if.array port  // Array access
);
    logic [7:0] mem [DEPTH];

    // Contents survive reset on purpose
    always_ff @(posedge clk)
    begin
        if (ce)
        begin
            if (port.we)
                mem[port.addr] <= port.wdata;
            if (port.re)
                port.rdata <= mem[port.addr];
        end
    end
endmodule : eedms_array
`default_nettype wire

// ==== design/eedms_pagebuf.sv ====
// Page buffer: one data byte and one tag per page entry
`timescale 1ns/1ns
`default_nettype none
module eedms_pagebuf #(
    parameter int DEPTH = 16,
    parameter int DW = 8
) (
    input wire logic clk,  // System clock
    input wire logic ce,  // Clock enable
    input wire logic rst_n,  // Synchronous reset
    input wire logic clr,  // Clear all entries
    input wire logic load,  // Load one entry
    input wire logic [$clog2(DEPTH)-1:0] ld_idx,  // Entry to load
    input wire logic [DW-1:0] ld_data,  // Byte to load
    input wire logic [$clog2(DEPTH)-1:0] rd_idx,  // Entry to read
    output logic [DW-1:0] rd_data,  // Byte of rd_idx
    output logic [DEPTH-1:0] tags  // Entry loaded flags
);
    localparam int IW = $clog2(DEPTH);
    logic [DW-1:0] ent [DEPTH];

    for (genvar i = 0; i < DEPTH; i++)
    begin : g_ent
        logic [DW-1:0] d;
        logic [DW-1:0] next_d;
        logic t;
        logic next_t;
        always_comb
        begin
            next_d = d;
            next_t = t;
            if (clr)
            begin
                next_d = '0;
                next_t = 1'b0;
            end
            else if (load && ld_idx == IW'(i))
            begin
                next_d = ld_data;
                next_t = 1'b1;
            end
        end
        always_ff @(posedge clk)
        begin
            if (!rst_n)
            begin
                d <= '0;
                t <= 1'b0;
            end
            else if (ce)
            begin
                d <= next_d;
                t <= next_t;
            end
        end
        assign ent[i] = d;
        assign tags[i] = t;
    end

    assign rd_data = ent[rd_idx];
endmodule : eedms_pagebuf
`default_nettype wire

// ==== design/eedms_seq.sv ====
// Data EEPROM sequencer with AXI4-Lite register port
// Functional notes
// (R1) Byte mode: read_start with read_enable reads the byte at the address pair.
// (R2) read_start without read_enable starts nothing.
// (R3) Read end: fetched byte goes to data register, then read_start clears.
// (R4) Data register keeps a read byte until the next read or write.
// (R5) Page read: address increments before read_start clears; repeat for next byte.
// (R6) Page bits never increment; low 4 bits stop at 0FH.
// (R7) Page buffer clears at reset and on erase_enable falling, not rising.
// (R8) Page erase: each data write tags the current address and increments.
// (R9) Software sets erase_enable then erase_start in consecutive cycles.
// (R10) Erase end clears erase_start and erase_enable; tagged bytes read zero.
// (R11) Erase and write durations come from an internal timer; poll or flag.
// (R12) Software loads address and data, then write_enable then write_start.
// (R13) write_start without write_enable starts no write.
// (R14) Write end clears write_start, then write_enable.
// (R15) Byte write is preceded automatically by an erase of that byte.
// (R16) Page write: data writes fill the buffer and increment; ignored after 0FH.
// (R17) Page buffer clears on write_enable falling, kept on rising.
// (R18) Software erases the page before a page write.
// (R19) write_enable is cleared at reset.
// (R20) Software masks global interrupts around activation.
// (R21) cycle_time_select: 0 gives 3.2ms/2.2ms, 1 gives 3.7ms/3.0ms.
// (R22) 512 bytes addressed by low register and one high bit.
// (R23) Erase or write end raises eeprom_irq_flag; software clears it.
// (R24) Software never sets read_start and write_start together.
// (R25) While busy, start requests and address/data writes are ignored.
`timescale 1ns/1ns
`default_nettype none
module eedms_seq #(
    parameter int ERASE_CYC0 = eedms_pkg::ERASE_T0_CYC,
    parameter int WRITE_CYC0 = eedms_pkg::WRITE_T0_CYC,
    parameter int ERASE_CYC1 = eedms_pkg::ERASE_T1_CYC,
    parameter int WRITE_CYC1 = eedms_pkg::WRITE_T1_CYC
) (
    input wire logic aclk,  // Clock
    input wire logic aresetn,  // Synchronous reset
    input wire logic ce,  // Clock enable
    input wire logic [eedms_pkg::AXI_AW-1:0] awaddr,  // Write address
    input wire logic awvalid,  // Write address valid
    output logic awready,  // Write address ready
    input wire logic [31:0] wdata,  // Write data
    input wire logic [3:0] wstrb,  // Write strobes
    input wire logic wvalid,  // Write data valid
    output logic wready,  // Write data ready
    output logic [1:0] bresp,  // Write response
    output logic bvalid,  // Write response valid
    input wire logic bready,  // Write response ready
    input wire logic [eedms_pkg::AXI_AW-1:0] araddr,  // Read address
    input wire logic arvalid,  // Read address valid
    output logic arready,  // Read address ready
    output logic [31:0] rdata,  // Read data
    output logic [1:0] rresp,  // Read response
    output logic rvalid,  // Read data valid
    input wire logic rready,  // Read data ready
    output logic eeprom_irq_flag  // Erase or write ended
);
    import eedms_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus slave state
    logic aw_held, next_aw_held;
    logic w_held, next_w_held;
    logic [AXI_AW-1:0] aw_q, next_aw_q;
    logic [7:0] wd_q, next_wd_q;
    logic ws_q, next_ws_q;
    logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic wr_en;

    // Core state
    eedms_state_t state, next_state;
    logic [7:0] addr_low, next_addr_low;
    logic addr_high, next_addr_high;
    logic [7:0] data_reg, next_data_reg;
    logic [7:0] ctl, next_ctl;
    logic next_irq;
    logic [TMR_W-1:0] tmr, next_tmr;
    logic [OFS_W-1:0] idx, next_idx;
    logic sat, next_sat;
    logic prev_ee, prev_we;
    logic buf_clr, buf_load;
    logic [7:0] buf_rd;
    logic [PAGE_BYTES-1:0] tags;
    logic arr_we, arr_re;
    logic [ARR_AW-1:0] arr_addr;
    logic [7:0] arr_wdata;
    logic [TMR_W-1:0] erase_cyc, write_cyc;

    eedms_arr_if #(.AW(ARR_AW), .DW(ARR_DW)) arr ();
    assign arr.we = arr_we;
    assign arr.re = arr_re;
    assign arr.addr = arr_addr;
    assign arr.wdata = arr_wdata;

    eedms_array #(.DEPTH(1 << ARR_AW)) u_array (
        .clk(aclk),
        .ce(ce),
        .port(arr.array)
    );

    eedms_pagebuf #(.DEPTH(PAGE_BYTES), .DW(ARR_DW)) u_pagebuf (
        .clk(aclk),
        .ce(ce),
        .rst_n(aresetn),
        .clr(buf_clr),
        .load(buf_load),
        .ld_idx(addr_low[OFS_W-1:0]),
        .ld_data(wd_q),
        .rd_idx(idx),
        .rd_data(buf_rd),
        .tags(tags)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave: one write and one read at a time
    assign wr_en = aw_held && w_held && !bvalid;

    always_comb
    begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_q = aw_q;
        next_wd_q = wd_q;
        next_ws_q = ws_q;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        if (awvalid && awready)
        begin
            next_aw_held = 1'b1;
            next_aw_q = awaddr;
        end
        if (wvalid && wready)
        begin
            next_w_held = 1'b1;
            next_wd_q = wdata[7:0];
            next_ws_q = wstrb[0];
        end
        if (bvalid && bready)
            next_bvalid = 1'b0;
        if (wr_en)
        begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = (aw_q > REG_STATUS || aw_q[1:0] != 2'b00) ? RESP_SLVERR : RESP_OKAY;
        end
        if (rvalid && rready)
            next_rvalid = 1'b0;
        if (arvalid && arready)
        begin
            next_rvalid = 1'b1;
            next_rresp = RESP_OKAY;
            case (araddr)
                REG_ADDR_LOW: next_rdata = {24'h000000, addr_low};
                REG_ADDR_HIGH: next_rdata = {31'h00000000, addr_high};
                REG_DATA: next_rdata = {24'h000000, data_reg};
                REG_CONTROL: next_rdata = {24'h000000, ctl};
                REG_STATUS: next_rdata = {31'h00000000, eeprom_irq_flag};
                default:
                begin
                    next_rdata = 32'h00000000;
                    next_rresp = RESP_SLVERR;
                end
            endcase
        end
        next_awready = !next_aw_held;
        next_wready = !next_w_held;
        next_arready = !next_rvalid;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_q <= '0;
            wd_q <= 8'h00;
            ws_q <= 1'b0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= RESP_OKAY;
        end
        else if (ce)
        begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_q <= next_aw_q;
            wd_q <= next_wd_q;
            ws_q <= next_ws_q;
            awready <= next_awready;
            wready <= next_wready;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            arready <= next_arready;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer
    assign erase_cyc = ctl[CTL_TIME_SEL] ? TMR_W'(ERASE_CYC1 - 1) : TMR_W'(ERASE_CYC0 - 1);  // R21
    assign write_cyc = ctl[CTL_TIME_SEL] ? TMR_W'(WRITE_CYC1 - 1) : TMR_W'(WRITE_CYC0 - 1);  // R21

    always_comb
    begin
        next_state = state;
        next_addr_low = addr_low;
        next_addr_high = addr_high;
        next_data_reg = data_reg;
        next_ctl = ctl;
        next_irq = eeprom_irq_flag;
        next_tmr = tmr;
        next_idx = idx;
        next_sat = sat;
        buf_load = 1'b0;
        buf_clr = (prev_ee && !ctl[CTL_ERASE_EN]) || (prev_we && !ctl[CTL_WRITE_EN]);  // R7 R17
        arr_re = 1'b0;
        arr_we = 1'b0;
        arr_addr = {addr_high, addr_low};  // R22
        arr_wdata = 8'h00;
        if (wr_en && ws_q)
        begin
            if (aw_q == REG_STATUS && !wd_q[STS_IRQ])
                next_irq = 1'b0;
            if (state == ST_IDLE)  // R25
            begin
                case (aw_q)
                    REG_ADDR_LOW:
                    begin
                        next_addr_low = wd_q;
                        next_sat = 1'b0;
                    end
                    REG_ADDR_HIGH:
                    begin
                        next_addr_high = wd_q[0];
                        next_sat = 1'b0;
                    end
                    REG_DATA:
                    begin
                        if (!ctl[CTL_MODE])
                            next_data_reg = wd_q;
                        else if (!sat)  // R16
                        begin
                            next_data_reg = wd_q;
                            buf_load = 1'b1;  // R8 R16
                            if (addr_low[OFS_W-1:0] == OFS_LAST)
                                next_sat = 1'b1;
                            else
                                next_addr_low[OFS_W-1:0] = addr_low[OFS_W-1:0] + 4'h1;  // R6 R8
                        end
                    end
                    REG_CONTROL:
                    begin
                        next_ctl = wd_q;
                        next_ctl[CTL_READ_GO] = wd_q[CTL_READ_GO] && ctl[CTL_READ_EN];  // R2
                        next_ctl[CTL_WRITE_GO] = wd_q[CTL_WRITE_GO] && ctl[CTL_WRITE_EN];  // R13
                        next_ctl[CTL_ERASE_GO] = wd_q[CTL_ERASE_GO] && ctl[CTL_ERASE_EN];
                    end
                    default:
                    begin
                    end
                endcase
            end
        end
        case (state)
            ST_IDLE:
            begin
                next_idx = '0;
                if (ctl[CTL_READ_GO])
                begin
                    arr_re = 1'b1;  // R1
                    next_state = ST_READ;
                end
                else if (ctl[CTL_WRITE_GO])
                begin
                    next_tmr = ctl[CTL_MODE] ? write_cyc : erase_cyc;  // R11 R15
                    next_state = ctl[CTL_MODE] ? ST_PROG : ST_ERASE;
                end
                else if (ctl[CTL_ERASE_GO])
                begin
                    next_tmr = erase_cyc;  // R11
                    next_state = ST_ERASE;
                end
            end
            ST_READ:
            begin
                next_data_reg = arr.rdata;  // R3 R4
                if (ctl[CTL_MODE] && addr_low[OFS_W-1:0] != OFS_LAST)
                    next_addr_low[OFS_W-1:0] = addr_low[OFS_W-1:0] + 4'h1;  // R5 R6
                next_ctl[CTL_READ_GO] = 1'b0;  // R3
                next_state = ST_IDLE;
            end
            ST_ERASE:
            begin
                if (tmr != '0)
                    next_tmr = tmr - TMR_W'(1);
                else if (ctl[CTL_WRITE_GO])
                begin
                    next_tmr = write_cyc;  // R15
                    next_state = ST_PROG;
                end
                else
                    next_state = ST_COMMIT;
            end
            ST_PROG:
            begin
                if (tmr != '0)
                    next_tmr = tmr - TMR_W'(1);
                else
                    next_state = ST_COMMIT;
            end
            ST_COMMIT:
            begin
                if (ctl[CTL_MODE])
                begin
                    arr_addr = {addr_high, addr_low[7:OFS_W], idx};
                    arr_we = tags[idx];
                    arr_wdata = ctl[CTL_WRITE_GO] ? buf_rd : 8'h00;  // R10
                    next_idx = idx + 4'h1;
                end
                else
                begin
                    arr_we = 1'b1;
                    arr_wdata = ctl[CTL_WRITE_GO] ? data_reg : 8'h00;
                end
                if (!ctl[CTL_MODE] || idx == OFS_LAST)
                begin
                    if (ctl[CTL_WRITE_GO])
                    begin
                        next_ctl[CTL_WRITE_GO] = 1'b0;  // R14
                        next_ctl[CTL_WRITE_EN] = 1'b0;  // R14
                    end
                    else
                    begin
                        next_ctl[CTL_ERASE_GO] = 1'b0;  // R10
                        next_ctl[CTL_ERASE_EN] = 1'b0;  // R10
                    end
                    next_irq = 1'b1;  // R23
                    next_state = ST_IDLE;
                end
            end
            default:
                next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state <= ST_IDLE;
            addr_low <= ADDR_LOW_RST;
            addr_high <= ADDR_HIGH_RST;
            data_reg <= DATA_RST;
            ctl <= CONTROL_RST;  // R19
            eeprom_irq_flag <= 1'b0;
            tmr <= '0;
            idx <= '0;
            sat <= 1'b0;
            prev_ee <= 1'b0;
            prev_we <= 1'b0;
        end
        else if (ce)
        begin
            state <= next_state;
            addr_low <= next_addr_low;
            addr_high <= next_addr_high;
            data_reg <= next_data_reg;
            ctl <= next_ctl;
            eeprom_irq_flag <= next_irq;
            tmr <= next_tmr;
            idx <= next_idx;
            sat <= next_sat;
            prev_ee <= ctl[CTL_ERASE_EN];
            prev_we <= ctl[CTL_WRITE_EN];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    a_rd_needs_en: assert property (@(posedge aclk) disable iff (!aresetn) // R2
        $rose(ctl[CTL_READ_GO]) |-> $past(ctl[CTL_READ_EN])) else $error("read started without enable");
    a_wr_needs_en: assert property (@(posedge aclk) disable iff (!aresetn) // R13
        $rose(ctl[CTL_WRITE_GO]) |-> $past(ctl[CTL_WRITE_EN])) else $error("write started without enable");
    a_rd_data_load: assert property (@(posedge aclk) disable iff (!aresetn) // R3
        $fell(ctl[CTL_READ_GO]) |-> data_reg == $past(arr.rdata)) else $error("read byte not loaded");
    a_wr_end_clear: assert property (@(posedge aclk) disable iff (!aresetn) // R14
        $fell(ctl[CTL_WRITE_GO]) |-> !ctl[CTL_WRITE_EN] && eeprom_irq_flag) else $error("write end not cleared");
    a_er_end_clear: assert property (@(posedge aclk) disable iff (!aresetn) // R10
        $fell(ctl[CTL_ERASE_GO]) |-> !ctl[CTL_ERASE_EN] && eeprom_irq_flag) else $error("erase end not cleared");
    a_ofs_saturate: assert property (@(posedge aclk) disable iff (!aresetn) // R6
        state == ST_READ && ctl[CTL_MODE] && addr_low[3:0] == OFS_LAST |=> addr_low[3:0] == OFS_LAST)
        else $error("offset rolled over");
    a_buf_cleared: assert property (@(posedge aclk) disable iff (!aresetn) // R7
        ce && ($fell(ctl[CTL_ERASE_EN]) || $fell(ctl[CTL_WRITE_EN])) |=> tags == '0) else $error("buffer not cleared");
    a_busy_hold: assert property (@(posedge aclk) disable iff (!aresetn) // R25
        state == ST_PROG |=> $stable(addr_low) && $stable(data_reg)) else $error("registers moved while busy");
endmodule : eedms_seq
`default_nettype wire

// ==== dv/eedms_host.sv ====
// Bus master model standing for the processor core
`timescale 1ns/1ns
`default_nettype none
module eedms_host (
    input wire logic aclk,  // Clock
    output logic [eedms_pkg::AXI_AW-1:0] awaddr,  // Write address
    output logic awvalid,  // Write address valid
    input wire logic awready,  // Write address ready
    output logic [31:0] wdata,  // Write data
    output logic wvalid,  // Write data valid
    input wire logic wready,  // Write data ready
    input wire logic [1:0] bresp,  // Write response
    input wire logic bvalid,  // Write response valid
    output logic bready,  // Write response ready
    output logic [eedms_pkg::AXI_AW-1:0] araddr,  // Read address
    output logic arvalid,  // Read address valid
    input wire logic arready,  // Read address ready
    input wire logic [31:0] rdata,  // Read data
    input wire logic [1:0] rresp,  // Read response
    input wire logic rvalid,  // Read data valid
    output logic rready  // Read data ready
);
    import eedms_pkg::*;
    initial
    begin
        awvalid = 1'b0;
        wvalid = 1'b0;
        arvalid = 1'b0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        bready = 1'b0;
        rready = 1'b0;
    end
    ////////////////////////////////////////
    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [AXI_AW-1:0] a, input logic [7:0] d, output logic [1:0] r);
        logic ta;
        logic td;
        ta = 1'b0;
        td = 1'b0;
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(ta && td))
        begin
            @(posedge aclk);
            if (!ta && awready === 1'b1)
            begin
                ta = 1'b1;
                awvalid <= 1'b0;
            end
            if (!td && wready === 1'b1)
            begin
                td = 1'b1;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        do @(posedge aclk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [AXI_AW-1:0] a, output logic [31:0] v, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(posedge aclk); while (rvalid !== 1'b1);
        v = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd
endmodule : eedms_host
`default_nettype wire

// ==== dv/tb_eedms_seq.sv ====
// Self-checking testbench of the data EEPROM sequencer
`timescale 1ns/1ns
`default_nettype none
module tb_eedms_seq;
    import eedms_pkg::*;
    logic aclk;
    logic aresetn;
    logic awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid, irq, irq_q, bready, rready, ce;
    logic [1:0] bresp, rresp;
    logic [31:0] wdata, rdata;
    logic [AXI_AW-1:0] awaddr, araddr;
    int n_fail = 0;
    int check_count = 0;
    int cyc = 0;
    int t_irq = 0;
    eedms_host h (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
    eedms_seq #(.ERASE_CYC0(20), .WRITE_CYC0(15), .ERASE_CYC1(25), .WRITE_CYC1(18)) i_dut (
        .aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .eeprom_irq_flag(irq));
    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // Cycle of each rising edge of the flag
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        irq_q <= irq;
        if (irq === 1'b1 && irq_q !== 1'b1)
            t_irq <= cyc;
    end
    ////////////////////////////////////////
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : cmp
    task automatic put(input logic [AXI_AW-1:0] a, input logic [7:0] d);
        logic [1:0] r;
        h.wr(a, d, r);
    endtask : put
    task automatic get(input logic [AXI_AW-1:0] a, input logic [7:0] e);
        logic [31:0] v;
        logic [1:0] r;
        h.rd(a, v, r);
        cmp(v, {24'h000000, e});
    endtask : get
    task automatic poll(input int b);
        logic [31:0] v;
        logic [1:0] r;
        do h.rd(REG_CONTROL, v, r); while (v[b] !== 1'b0);
    endtask : poll
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : report_and_stop
    initial
    begin
        #300000;
        n_fail++;
        report_and_stop;
    end
    initial
    begin
        logic [31:0] v;
        logic [1:0] r;
        int t0;
        int dt[2];
        aresetn = 1'b0;
        ce = 1'b1;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        get(REG_CONTROL, CONTROL_RST);
        get(REG_DATA, DATA_RST);
        h.rd(5'h14, v, r);
        cmp(r, RESP_SLVERR);
        h.wr(5'h14, 8'h00, r);
        cmp(r, RESP_SLVERR);
        put(REG_CONTROL, 8'h01);
        get(REG_CONTROL, 8'h00);
        put(REG_CONTROL, 8'h04);
        get(REG_CONTROL, 8'h00);
        get(REG_STATUS, 8'h00);
        $display("done: refusals");
        for (int s = 0; s < 2; s++)
        begin
            put(REG_ADDR_HIGH, 8'h01);
            put(REG_ADDR_LOW, 8'h23);
            put(REG_DATA, 8'ha5);
            put(REG_CONTROL, {s[0], 7'h08});
            put(REG_CONTROL, {s[0], 7'h0c});
            t0 = cyc;
            ce <= !s[0];
            repeat (5) @(posedge aclk);
            ce <= 1'b1;
            put(REG_ADDR_LOW, 8'h77);
            poll(CTL_WRITE_GO);
            get(REG_CONTROL, {s[0], 7'h00});
            get(REG_ADDR_LOW, 8'h23);
            get(REG_STATUS, 8'h01);
            dt[s] = t_irq - t0;
            put(REG_STATUS, 8'h00);
            get(REG_STATUS, 8'h00);
        end
        cmp(32'(dt[1] - dt[0]), 32'd13);
        put(REG_CONTROL, 8'h02);
        put(REG_CONTROL, 8'h03);
        poll(CTL_READ_GO);
        get(REG_DATA, 8'ha5);
        get(REG_DATA, 8'ha5);
        $display("done: byte access");
        put(REG_CONTROL, 8'h10);
        put(REG_ADDR_LOW, 8'h20);
        for (int i = 0; i < 16; i++)
            put(REG_DATA, 8'h5a);
        get(REG_ADDR_LOW, 8'h2f);
        put(REG_CONTROL, 8'h50);
        put(REG_CONTROL, 8'h70);
        poll(CTL_ERASE_GO);
        get(REG_CONTROL, 8'h10);
        put(REG_ADDR_LOW, 8'h23);
        put(REG_CONTROL, 8'h12);
        put(REG_CONTROL, 8'h13);
        poll(CTL_READ_GO);
        get(REG_DATA, 8'h00);
        $display("done: page erase");
        put(REG_ADDR_LOW, 8'h20);
        for (int i = 0; i < 17; i++)
            put(REG_DATA, 8'(i * 3 + 1));
        put(REG_CONTROL, 8'h18);
        put(REG_CONTROL, 8'h1c);
        poll(CTL_WRITE_GO);
        get(REG_CONTROL, 8'h10);
        put(REG_ADDR_LOW, 8'h20);
        put(REG_CONTROL, 8'h12);
        for (int i = 0; i < 17; i++)
        begin
            put(REG_CONTROL, 8'h13);
            poll(CTL_READ_GO);
            get(REG_DATA, 8'((i > 15 ? 15 : i) * 3 + 1));
        end
        get(REG_ADDR_LOW, 8'h2f);
        get(REG_ADDR_HIGH, 8'h01);
        $display("done: page write and read");
        report_and_stop;
    end
endmodule : tb_eedms_seq
`default_nettype wire
